// file: rtl/ptc_defs.svh
// Constants for the transmit-clock phase and DSP configuration bank.
// Assumes the includer reaches registers by word index; byte address = 4 * index.
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH

// Register word indexes.
`define PTC_IDX_PHASE 10'h042
`define PTC_IDX_DSP1 10'h101
`define PTC_IDX_DFC1 10'h106
`define PTC_IDX_DFC2 10'h107
`define PTC_IDX_DSP2 10'h10f
`define PTC_IDX_DSP3 10'h111
`define PTC_IDX_FEQ 10'h114
`define PTC_IDX_GBW 10'h116
`define PTC_IDX_MSE_BAD 10'h121
`define PTC_IDX_MSE_GOOD 10'h122

// Reset values.
`define PTC_RST_PHASE 4'h0
`define PTC_RST_DSP1 16'h2000
`define PTC_RST_DFC1 16'hb0bb
`define PTC_RST_DFC2 16'h0605
`define PTC_RST_DSP2 16'h0300
`define PTC_RST_DSP3 16'h6003
`define PTC_RST_FEQ 16'h400a
`define PTC_RST_GBW 16'h014a
`define PTC_RST_MSE_BAD 16'h199a
`define PTC_RST_MSE_GOOD 16'h1027

// Writable-bit masks.
`define PTC_MASK_FULL 16'hffff
`define PTC_MASK_MSE 16'h7fff

// Field positions.
`define PTC_PH_TRIG_BIT 4
`define PTC_PH_VAL_MSB 3
`define PTC_DSP1_FILT_DIS_BIT 7
`define PTC_DFC1_THR1_MSB 15
`define PTC_DFC1_THR1_LSB 12
`define PTC_DFC1_COEF_EN_BIT 10
`define PTC_DFC1_LONG_MSB 7
`define PTC_DFC1_LONG_LSB 6
`define PTC_DFC1_THR0_MSB 3
`define PTC_DSP2_LOOP_BIT 8
`define PTC_DSP3_GAIN_MSB 3
`define PTC_MSE_MSB 14

`endif

// file: rtl/ptc_pkg.sv
// Types shared by the phase and DSP configuration bank.
// Assumes constants come from ptc_defs.svh.
package ptc_pkg;

    // Register selected by an APB address.
    typedef enum {
        REG_PHASE, REG_DSP1, REG_DFC1, REG_DFC2, REG_DSP2,
        REG_DSP3, REG_FEQ, REG_GBW, REG_MSE_BAD, REG_MSE_GOOD, REG_NONE
    } ptc_reg_t;

    // Phase trigger progress in the bus domain.
    typedef enum {TRIG_IDLE, TRIG_WAIT} ptc_trig_t;

endpackage : ptc_pkg

// file: rtl/ptc_phase_if.sv
// Carrier of the phase request handshake between bus and link domains.
// Assumes the bus side holds req_phase stable while req_tgl differs from ack_tgl.
`timescale 1ns/100ps
interface ptc_phase_if;
    logic req_tgl; // Flips once per phase request.
    logic [3:0] req_phase; // Requested phase in 4 ns steps.
    logic ack_tgl; // Follows req_tgl once the link side applied it.
    modport core (output req_tgl, output req_phase, input ack_tgl);
    modport link (input req_tgl, input req_phase, output ack_tgl);
endinterface : ptc_phase_if

// file: rtl/ptc_txclk_shifter.sv
// Link-domain end of the transmit-clock phase shifter.
// Assumes link_clock is the reference clock and drives the delay line select.
`timescale 1ns/100ps
`include "ptc_defs.svh"
module ptc_txclk_shifter (
    input wire logic link_clock,
    input wire logic arst_n,
    ptc_phase_if.link ph,
    output logic [3:0] tx_clk_delay_sel
);
    logic rst_meta; // Reset release synchroniser, first stage.
    logic rst_sync_n; // Reset release synchronised to link_clock.
    logic req_meta; // Request toggle, first stage.
    logic req_sync; // Request toggle, second stage.
    logic req_seen; // Last request toggle acted on.
    logic ack; // Acknowledge toggle.

    // Release reset only on a link edge so no flop leaves reset mid-cycle.
    always_ff @(posedge link_clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // New request seen when the synchronised toggle differs from the last one.
    wire new_req = req_sync != req_seen;

    // The word req_phase is stable by the time the toggle arrives here.
    always_ff @(posedge link_clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_seen <= 1'b0;
            ack <= 1'b0;
            tx_clk_delay_sel <= `PTC_RST_PHASE;
        end
        else
        begin
            req_meta <= ph.req_tgl;
            req_sync <= req_meta;
            if (new_req)
            begin
                // Delay 4 ns per step, so the move is 4 ns times the difference.
                tx_clk_delay_sel <= ph.req_phase; // R1 R4
                req_seen <= req_sync;
                ack <= req_sync;
            end
        end
    end

    assign ph.ack_tgl = ack;

    a_link_hold: assert property (@(posedge link_clock) disable iff (!rst_sync_n) // R2
        !new_req |=> $stable(tx_clk_delay_sel))
        else $error("Delay select moved without a request.");

endmodule : ptc_txclk_shifter

// file: rtl/ptc_regbank.sv
// Transmit-clock phase shifter control and DSP configuration registers.
// Assumes an APB master on clock and DSP logic on the same clock.
//
// Functional notes
// R1 - Trigger bit applies phase, then self-clears.
// R2 - Trigger zero keeps transmit clock phase.
// R3 - Bits 3:0 show current phase, reset 0000.
// R4 - Shift equals four ns times value difference.
// R5 - Bit 7 disables filter during training.
// R6 - Bits 15:12 set short cable set1 threshold.
// R7 - Bits 3:0 set short cable set0 threshold.
// R8 - Bit 10 enables steady state coefficient.
// R9 - Bits 7:6 give long cable coefficients.
// R10 - Bit 8 selects gain loop input.
// R11 - Gain index loads start value at training.
// R12 - Error above bad threshold enters recovery.
// R13 - Good threshold judges timing loop convergence.
// R14 - Reserved writable bits keep written values.
`timescale 1ns/100ps
`include "ptc_defs.svh"
module ptc_regbank (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic link_clock,
    // APB slave port; it never inserts wait states.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Delay line select, driven from the link domain.
    output logic [3:0] tx_clk_delay_sel,
    // Levels read by the DSP straight from the configuration words.
    output logic filter_disable_training,
    output logic [3:0] short_thr_set1,
    output logic [3:0] short_thr_set0,
    output logic steady_filter_en,
    output logic [1:0] long_cable_coef,
    output logic gain_loop_input_sel,
    // Gain training start and the index it seeds.
    input wire logic gain_train_start,
    output logic [3:0] gain_index,
    // Error samples from the 100 Mbps receiver.
    input wire logic speed_100,
    input wire logic dsp_steady,
    input wire logic mse_valid,
    input wire logic [14:0] mse_value,
    output logic enter_recovery,
    output logic timing_converged
);

    // Maps a word index to a register; used for reads and writes alike.
    // The caller drops the two byte-select bits of the address.
    function automatic ptc_pkg::ptc_reg_t decode(input logic [9:0] idx);
        case (idx)
            `PTC_IDX_PHASE: decode = ptc_pkg::REG_PHASE;
            `PTC_IDX_DSP1: decode = ptc_pkg::REG_DSP1;
            `PTC_IDX_DFC1: decode = ptc_pkg::REG_DFC1;
            `PTC_IDX_DFC2: decode = ptc_pkg::REG_DFC2;
            `PTC_IDX_DSP2: decode = ptc_pkg::REG_DSP2;
            `PTC_IDX_DSP3: decode = ptc_pkg::REG_DSP3;
            `PTC_IDX_FEQ: decode = ptc_pkg::REG_FEQ;
            `PTC_IDX_GBW: decode = ptc_pkg::REG_GBW;
            `PTC_IDX_MSE_BAD: decode = ptc_pkg::REG_MSE_BAD;
            `PTC_IDX_MSE_GOOD: decode = ptc_pkg::REG_MSE_GOOD;
            default: decode = ptc_pkg::REG_NONE;
        endcase
    endfunction : decode

    // Reset values and writable bits of the plain configuration words.
    localparam logic [15:0] CFG_RESET [1:9] = '{`PTC_RST_DSP1, `PTC_RST_DFC1,
        `PTC_RST_DFC2, `PTC_RST_DSP2, `PTC_RST_DSP3, `PTC_RST_FEQ, `PTC_RST_GBW,
        `PTC_RST_MSE_BAD, `PTC_RST_MSE_GOOD};
    // Bit 15 of both error thresholds reads zero and ignores writes.
    localparam logic [15:0] CFG_WMASK [1:9] = '{`PTC_MASK_FULL, `PTC_MASK_FULL,
        `PTC_MASK_FULL, `PTC_MASK_FULL, `PTC_MASK_FULL, `PTC_MASK_FULL,
        `PTC_MASK_FULL, `PTC_MASK_MSE, `PTC_MASK_MSE};

    ptc_phase_if ph (); // Handshake toward the link domain.

    logic [15:0] cfg [1:9]; // Configuration words, reserved bits included.
    logic [3:0] applied_phase; // Phase known to be applied at the link.
    ptc_pkg::ptc_trig_t trig_state; // Trigger progress.
    ptc_pkg::ptc_trig_t next_trig_state; // Trigger progress, next value.
    logic req_tgl; // Request toggle toward the link.
    logic [3:0] req_phase; // Phase word held during the handshake.
    logic ack_meta; // Acknowledge toggle, first stage.
    logic ack_sync; // Acknowledge toggle, second stage.

    // Address decode and transfer phases.
    wire setup = psel && !penable;
    wire access = psel && penable;
    // An enum is a two-state type, so the decoded register is a variable.
    ptc_pkg::ptc_reg_t sel;
    assign sel = decode(paddr[11:2]);
    wire hit = sel != ptc_pkg::REG_NONE;
    wire wr = access && pwrite && hit;
    wire [3:0] cfg_num = 4'(int'(sel));
    // Registers are 16 bits wide, so only the two low byte lanes count.
    wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // The slave never stalls; unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign pslverr = access && !hit;

    // Trigger is taken only with its byte lane and only when idle.
    wire trig_busy = trig_state == ptc_pkg::TRIG_WAIT;
    wire trig_write = wr && sel == ptc_pkg::REG_PHASE && pstrb[0]
        && pwdata[`PTC_PH_TRIG_BIT] && !trig_busy;
    wire ack_done = ack_sync == req_tgl;

    // Trigger state: request goes out, bit clears once the link echoes it.
    always_comb
    begin
        next_trig_state = trig_state;
        case (trig_state)
            ptc_pkg::TRIG_IDLE:
            begin
                // Without a trigger write the phase is left alone.
                if (trig_write)
                    next_trig_state = ptc_pkg::TRIG_WAIT; // R1 R2
            end
            ptc_pkg::TRIG_WAIT:
            begin
                // Self-clear after the link side acknowledged.
                if (ack_done)
                    next_trig_state = ptc_pkg::TRIG_IDLE; // R1
            end
            // An illegal state falls back to idle.
            default: next_trig_state = ptc_pkg::TRIG_IDLE;
        endcase
    end

    // State register and request launch.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trig_state <= ptc_pkg::TRIG_IDLE;
            req_tgl <= 1'b0;
            req_phase <= `PTC_RST_PHASE;
        end
        else
        begin
            trig_state <= next_trig_state;
            // A toggle crosses safely whatever the ratio of the two clocks.
            if (trig_write)
            begin
                // Word set on the same edge the toggle flips and held until acknowledged.
                req_phase <= pwdata[`PTC_PH_VAL_MSB:0]; // R4
                req_tgl <= !req_tgl;
            end
        end
    end

    // Acknowledge synchroniser; only ack_sync is read by logic.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end
        else
        begin
            ack_meta <= ph.ack_tgl;
            ack_sync <= ack_meta;
        end
    end

    // The reported phase follows the link only after the echo returns.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            applied_phase <= `PTC_RST_PHASE; // R3
        else if (trig_busy && ack_done)
            applied_phase <= req_phase; // R3 R4
    end

    // Request side of the handshake carrier.
    assign ph.req_tgl = req_tgl;
    assign ph.req_phase = req_phase;

    // Link-domain shifter; it alone drives the delay select.
    ptc_txclk_shifter u_shifter (
        .link_clock(link_clock),
        .arst_n(arst_n),
        .ph(ph.link),
        .tx_clk_delay_sel(tx_clk_delay_sel)
    );

    // Configuration words; every writable bit keeps what was written.
    for (genvar g = 1; g < 10; g++)
    begin : g_cfg
        wire [15:0] wbits = lane_mask & CFG_WMASK[g];
        always_ff @(posedge clock or negedge arst_n)
        begin
            if (!arst_n)
                cfg[g] <= CFG_RESET[g];
            else if (wr && cfg_num == 4'(g))
                cfg[g] <= (cfg[g] & ~wbits) | (pwdata[15:0] & wbits); // R14
        end
    end

    // Read word; upper phase bits and bit 15 of error thresholds read zero.
    wire [15:0] rd_phase = {11'h000, trig_busy, applied_phase}; // R3
    // Unmapped words read as zero.
    wire cfg_hit = hit && sel != ptc_pkg::REG_PHASE;
    wire [15:0] rd_word = (sel == ptc_pkg::REG_PHASE) ? rd_phase
        : (cfg_hit ? cfg[cfg_num] : 16'h0000);

    // Read data is captured in the setup cycle and shown in the access cycle.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata <= {16'h0000, rd_word};
    end

    // Configuration fields seen by the DSP.
    assign filter_disable_training = cfg[1][`PTC_DSP1_FILT_DIS_BIT]; // R5
    assign short_thr_set1 = cfg[2][`PTC_DFC1_THR1_MSB:`PTC_DFC1_THR1_LSB]; // R6
    assign short_thr_set0 = cfg[2][`PTC_DFC1_THR0_MSB:0]; // R7
    assign steady_filter_en = cfg[2][`PTC_DFC1_COEF_EN_BIT]; // R8
    assign long_cable_coef = cfg[2][`PTC_DFC1_LONG_MSB:`PTC_DFC1_LONG_LSB]; // R9
    assign gain_loop_input_sel = cfg[4][`PTC_DSP2_LOOP_BIT]; // R10

    // Thresholds compared only in 100 Mbps operation.
    wire [14:0] bad_thr = cfg[8][`PTC_MSE_MSB:0];
    wire [14:0] good_thr = cfg[9][`PTC_MSE_MSB:0];
    wire mse_live = mse_valid && speed_100;
    // Recovery is judged only from steady state.
    wire mse_bad = mse_live && dsp_steady && mse_value > bad_thr;

    // Gain index seeds from the start value when gain training begins.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            // Only the low nibble of the start-gain word seeds the index.
            gain_index <= 4'(`PTC_RST_DSP3);
        else if (gain_train_start)
            gain_index <= cfg[5][`PTC_DSP3_GAIN_MSB:0]; // R11
    end

    // Recovery is high for one cycle per bad sample; convergence is a level updated per sample.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            enter_recovery <= 1'b0;
            timing_converged <= 1'b0;
        end
        else
        begin
            enter_recovery <= mse_bad; // R12
            // Samples at 10 Mbps leave the convergence level alone.
            if (mse_live)
                timing_converged <= mse_value <= good_thr; // R13
        end
    end

    // Every check below is on the core clock and idle while reset is low.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // A trigger reads busy, then clears once the link echoes it.
    a_trig_self_clear: assert property (trig_write |=> trig_busy ##[1:40] !trig_busy) // R1
        else $error("Trigger bit did not self-clear.");

    // Without a trigger the reported phase stays put.
    a_phase_unchanged: assert property (!trig_busy && !trig_write |=> $stable(applied_phase)) // R2
        else $error("Phase changed without a trigger.");

    // A phase read returns the phase applied at its setup cycle.
    a_phase_readback: assert property (setup && !pwrite && sel == ptc_pkg::REG_PHASE // R3
        |=> prdata[3:0] == $past(applied_phase))
        else $error("Phase readback differs from applied phase.");

    // The written value is held, reaches the delay select and is reported.
    a_phase_applied: assert property (trig_write |=> req_phase == $past(pwdata[3:0]) // R4
        ##[1:40] (!trig_busy && applied_phase == req_phase && tx_clk_delay_sel == req_phase))
        else $error("Written phase not applied.");

    // The training filter disable follows the low byte lane.
    a_filter_disable: assert property (wr && sel == ptc_pkg::REG_DSP1 && pstrb[0] // R5
        |=> filter_disable_training == $past(pwdata[7]))
        else $error("Filter disable not taken.");

    // The set1 threshold follows the high byte lane.
    a_short_thr_one: assert property (wr && sel == ptc_pkg::REG_DFC1 && pstrb[1] // R6
        |=> short_thr_set1 == $past(pwdata[15:12]))
        else $error("Set1 threshold not taken.");

    // The set0 threshold follows the low byte lane.
    a_short_thr_zero: assert property (wr && sel == ptc_pkg::REG_DFC1 && pstrb[0] // R7
        |=> short_thr_set0 == $past(pwdata[3:0]))
        else $error("Set0 threshold not taken.");

    // The steady-state enable follows the high byte lane.
    a_steady_coef: assert property (wr && sel == ptc_pkg::REG_DFC1 && pstrb[1] // R8
        |=> steady_filter_en == $past(pwdata[10]))
        else $error("Steady coefficient enable not taken.");

    // The long cable coefficients follow the low byte lane.
    a_long_coef: assert property (wr && sel == ptc_pkg::REG_DFC1 && pstrb[0] // R9
        |=> long_cable_coef == $past(pwdata[7:6]))
        else $error("Long cable coefficients not taken.");

    // The gain loop select follows the high byte lane.
    a_loop_select: assert property (wr && sel == ptc_pkg::REG_DSP2 && pstrb[1] // R10
        |=> gain_loop_input_sel == $past(pwdata[8]))
        else $error("Gain loop select not taken.");

    // Training start seeds the index from the start value.
    a_gain_load: assert property (gain_train_start |=> gain_index == $past(cfg[5][3:0])) // R11
        else $error("Gain index not loaded.");

    // A steady sample above the bad threshold raises recovery.
    a_recovery_entry: assert property (mse_live && dsp_steady && mse_value > bad_thr // R12
        |=> enter_recovery)
        else $error("Recovery not entered above bad threshold.");

    // Each 100 Mbps sample sets the convergence level.
    a_converge_judge: assert property (mse_live |=> timing_converged == ($past(mse_value) <= $past(good_thr))) // R13
        else $error("Convergence misjudged.");

    // A full write to a reserved word reads back unchanged.
    a_reserved_keep: assert property (wr && sel == ptc_pkg::REG_DFC2 && pstrb[1:0] == 2'b11 // R14
        |=> cfg[3] == $past(pwdata[15:0]))
        else $error("Reserved word did not keep written value.");

    // Main scenarios: a phase move, recovery, an unmapped access, convergence.
    c_phase_shift: cover property (trig_write ##[1:40] !trig_busy);
    c_recovery: cover property (enter_recovery);
    c_unmapped: cover property (pslverr);
    c_converged: cover property ($rose(timing_converged));
    c_gain_load: cover property (gain_train_start);

endmodule : ptc_regbank

// file: test/ptc_mac_model.sv
// Behavioural model of the MAC that receives the shifted transmit clock.
// Assumes the delay select moves the transmit clock by 4 ns per step.
`timescale 1ns/100ps
module ptc_mac_model (
    input wire logic link_clock,
    input wire logic arst_n,
    input wire logic [3:0] delay_sel,
    output logic signed [7:0] shift_ns,
    output logic [7:0] shift_count
);
    // Last select seen, so that each move is measured against it.
    logic [3:0] last_sel;

    // Sampled on the falling edge so a move made at a rising edge is seen half a period later.
    always_ff @(negedge link_clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            last_sel <= 4'h0;
            shift_ns <= 8'sh00;
            shift_count <= 8'h00;
        end
        else if (delay_sel != last_sel)
        begin
            // The MAC sees the edge move by the step difference times 4 ns.
            last_sel <= delay_sel;
            shift_ns <= 8'sh04 * ($signed({4'h0, delay_sel}) - $signed({4'h0, last_sel}));
            shift_count <= shift_count + 8'h01;
        end
    end
endmodule : ptc_mac_model

// file: test/ptc_regbank_tb_top.sv
// Self-checking bench for the phase shifter and DSP configuration bank.
// Assumes the design files and the MAC model are compiled before it.
`timescale 1ns/100ps
`include "ptc_defs.svh"
module ptc_regbank_tb_top;
    logic clock = 1'b0;
    logic link_clock = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h3;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [3:0] delay_sel, thr1, thr0, gain_index;
    logic filt_dis, steady_en, loop_sel, enter_recovery, timing_converged;
    logic [1:0] long_coef;
    logic gain_train_start = 1'b0, speed_100 = 1'b0, dsp_steady = 1'b0, mse_valid = 1'b0;
    logic [14:0] mse_value = 15'h0;
    logic signed [7:0] shift_ns;
    logic [7:0] shift_count;
    int err_count = 0;
    int num_checks = 0;
    int seed = 32'h1d52;
    // Register table: word index, reset value and writable mask.
    logic [9:0] idx [10] = '{`PTC_IDX_PHASE, `PTC_IDX_DSP1, `PTC_IDX_DFC1, `PTC_IDX_DFC2, `PTC_IDX_DSP2,
        `PTC_IDX_DSP3, `PTC_IDX_FEQ, `PTC_IDX_GBW, `PTC_IDX_MSE_BAD, `PTC_IDX_MSE_GOOD};
    logic [15:0] rst [10] = '{16'h0, `PTC_RST_DSP1, `PTC_RST_DFC1, `PTC_RST_DFC2, `PTC_RST_DSP2,
        `PTC_RST_DSP3, `PTC_RST_FEQ, `PTC_RST_GBW, `PTC_RST_MSE_BAD, `PTC_RST_MSE_GOOD};
    logic [15:0] msk [10] = '{16'h0, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
        `PTC_MASK_MSE, `PTC_MASK_MSE};
    logic [15:0] shadow [10];

    ptc_regbank ptc_regbank_inst (.clock(clock), .arst_n(arst_n), .link_clock(link_clock), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_clk_delay_sel(delay_sel), .filter_disable_training(filt_dis),
        .short_thr_set1(thr1), .short_thr_set0(thr0), .steady_filter_en(steady_en),
        .long_cable_coef(long_coef), .gain_loop_input_sel(loop_sel), .gain_train_start(gain_train_start),
        .gain_index(gain_index), .speed_100(speed_100), .dsp_steady(dsp_steady), .mse_valid(mse_valid),
        .mse_value(mse_value), .enter_recovery(enter_recovery), .timing_converged(timing_converged));

    ptc_mac_model ptc_mac_model_inst (.link_clock(link_clock), .arst_n(arst_n), .delay_sel(delay_sel),
        .shift_ns(shift_ns), .shift_count(shift_count));

    // Core clock at 100 MHz.
    initial
    begin
        forever #5 clock = ~clock;
    end

    // Link clock at a 30 ns period, offset so its edges never line up with the core clock.
    initial
    begin
        #7;
        forever #15 link_clock = ~link_clock;
    end

    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; the request stands until pready is seen high, then a spare edge passes.
    task automatic apb(input logic wr, input logic [9:0] ix, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    // Recovery is expected only for a steady 100M sample strictly above the bad threshold.
    function automatic logic exp_rec(input logic sp, input logic st, input logic [14:0] v, input logic [14:0] t);
        return sp && st && (v > t);
    endfunction : exp_rec

    // Every configuration output must mirror its field in the shadow copy.
    task automatic check_cfg();
        chk("filter_disable_training", 32'(shadow[1][7]), 32'(filt_dis));
        chk("short_thr_set1", 32'(shadow[2][15:12]), 32'(thr1));
        chk("short_thr_set0", 32'(shadow[2][3:0]), 32'(thr0));
        chk("steady_filter_en", 32'(shadow[2][10]), 32'(steady_en));
        chk("long_cable_coef", 32'(shadow[2][7:6]), 32'(long_coef));
        chk("gain_loop_input_sel", 32'(shadow[4][8]), 32'(loop_sel));
    endtask : check_cfg

    // Prints the verdict and ends the run; also reached from the watchdog.
    task automatic finish_test();
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    // Watchdog: the sequence needs a few hundred cycles, so this span means a hang.
    initial
    begin
        #400000;
        err_count++;
        finish_test();
    end

    // Main sequence.
    initial
    begin
        logic [31:0] q, d;
        logic e, cexp;
        int i, nv, ov, moves;
        logic [14:0] v;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        // Leave time for the link-side reset synchroniser before any phase trigger.
        repeat (12) @(posedge clock);
        for (i = 0; i < 10; i++)
        begin
            apb(1'b0, idx[i], 32'h0, q, e);
            chk("reset_value", {16'h0, rst[i]}, q);
            shadow[i] = rst[i];
        end
        check_cfg();
        chk("gain_index_reset", 32'h3, 32'(gain_index));
        // Unmapped places are refused with an error and read as zero.
        apb(1'b1, 10'h3ff, 32'hffff, q, e);
        chk("unmapped_write_err", 32'h1, 32'(e));
        apb(1'b0, 10'h000, 32'h0, q, e);
        chk("unmapped_read_err", 32'h1, 32'(e));
        chk("unmapped_read_data", 32'h0, q);
        // Random contents in every configuration word, reserved bits included.
        for (i = 1; i < 10; i++)
        begin
            d = $random(seed);
            shadow[i] = d[15:0] & msk[i];
            apb(1'b1, idx[i], d, q, e);
            apb(1'b0, idx[i], 32'h0, q, e);
            chk("readback", {16'h0, shadow[i]}, q);
        end
        check_cfg();
        // Gain training start loads the starting index.
        gain_train_start <= 1'b1;
        @(posedge clock);
        gain_train_start <= 1'b0;
        #1;
        chk("gain_index", 32'(shadow[5][3:0]), 32'(gain_index));
        // Phase moves: hand-picked 2 then 9 (a 28 ns move), then random values.
        ov = 0;
        moves = 0;
        @(posedge clock);
        for (i = 0; i < 5; i++)
        begin
            nv = (i == 0) ? 2 : (i == 1) ? 9 : ($random(seed) & 15);
            apb(1'b1, `PTC_IDX_PHASE, nv, q, e);
            apb(1'b0, `PTC_IDX_PHASE, 32'h0, q, e);
            chk("phase_without_trigger", ov, q);
            chk("delay_sel_held", ov, 32'(delay_sel));
            apb(1'b1, `PTC_IDX_PHASE, 32'h10 | nv, q, e);
            apb(1'b0, `PTC_IDX_PHASE, 32'h0, q, e);
            chk("trigger_pending", 32'h1, 32'(q[4]));
            for (int n = 0; n < 20 && q[4] !== 1'b0; n++)
                apb(1'b0, `PTC_IDX_PHASE, 32'h0, q, e);
            chk("phase_value", nv, q);
            chk("delay_sel", nv, 32'(delay_sel));
            moves += (nv != ov);
            if (nv != ov)
                chk("shift_ns", 4 * (nv - ov), 32'(shift_ns));
            ov = nv;
        end
        chk("shift_count", moves, 32'(shift_count));
        // Error samples: four threshold corners, then random ones, with speed and steady state dropped once.
        cexp = 1'b0;
        for (i = 0; i < 16; i++)
        begin
            v = (i == 0) ? shadow[8][14:0] : (i == 1) ? shadow[8][14:0] + 15'h1 :
                (i == 2) ? shadow[9][14:0] : (i == 3) ? shadow[9][14:0] + 15'h1 : 15'($random(seed));
            speed_100 <= (i != 5);
            dsp_steady <= (i != 6);
            mse_valid <= 1'b1;
            mse_value <= v;
            @(posedge clock);
            mse_valid <= 1'b0;
            if (i != 5)
                cexp = (v <= shadow[9][14:0]);
            #1;
            chk("enter_recovery", 32'(exp_rec(i != 5, i != 6, v, shadow[8][14:0])), 32'(enter_recovery));
            chk("timing_converged", 32'(cexp), 32'(timing_converged));
            @(posedge clock);
            #1;
            chk("recovery_pulse_end", 32'h0, 32'(enter_recovery));
            @(posedge clock);
        end
        finish_test();
    end
endmodule : ptc_regbank_tb_top
